/* File: core/stx_pkg.sv */
package stx_pkg;

  // Widths
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned PROG_W  = 14;
  localparam int unsigned PC_W    = 10;
  localparam int unsigned RAM_AW  = 5;
  localparam int unsigned HIGH_W  = PROG_W - DATA_W;

  // Operation select codes, one-hot except STX_OP_NONE
  typedef enum logic [7:0] {
    STX_OP_NONE        = 8'h00,
    STX_OP_SKIP_ZERO   = 8'h01,
    STX_OP_MOVE_SKIP   = 8'h02,
    STX_OP_SKIP_BIT    = 8'h04,
    STX_OP_TABLE_CUR   = 8'h08,
    STX_OP_TABLE_LAST  = 8'h10,
    STX_OP_XOR_ACC     = 8'h20,
    STX_OP_XOR_MEM     = 8'h40,
    STX_OP_XOR_IMM     = 8'h80
  } stx_op_t;

  // Sequencer states
  typedef enum logic [2:0] {
    STX_ST_EXEC  = 3'b001,
    STX_ST_DUMMY = 3'b010,
    STX_ST_TABLE = 3'b100
  } stx_state_t;

  // Reset values
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [5:0] HIGH_RST  = 6'h00;
  localparam logic [9:0] PC_RST    = 10'h000;
  // Page base of last page: top 2 address bits set
  localparam logic [1:0] LAST_PAGE = 2'h3;

endpackage

/* File: core/stx_ram.sv */
`timescale 1ns/1ps
module stx_ram
(
  input  wire logic                          mclk,
  input  wire logic                          wr_en,
  input  wire logic [stx_pkg::RAM_AW-1:0]    addr,
  input  wire logic [stx_pkg::DATA_W-1:0]    wr_data,
  output logic      [stx_pkg::DATA_W-1:0]    rd_data_q
);

  logic [stx_pkg::DATA_W-1:0] mem_q [0:(1<<stx_pkg::RAM_AW)-1];

  // Write-through keeps read data fresh after a write
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem_q[addr] <= wr_data;
      rd_data_q   <= wr_data;
    end
    else
    begin
      rd_data_q <= mem_q[addr];
    end
  end

endmodule

/* File: core/stx_exec.sv */
`timescale 1ns/1ps
module stx_exec
(
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          op_valid,
  input  wire stx_pkg::stx_op_t              op_sel,
  input  wire logic [stx_pkg::RAM_AW-1:0]    mem_addr,
  input  wire logic [2:0]                    bit_sel,
  input  wire logic [stx_pkg::DATA_W-1:0]    imm_data,
  input  wire logic [stx_pkg::DATA_W-1:0]    table_pointer,
  input  wire logic [stx_pkg::PROG_W-1:0]    prog_rd_data,
  output logic                               op_ready_q,
  output logic                               op_done_q,
  output logic                               skip_q,
  output logic      [stx_pkg::PC_W-1:0]      pc_q,
  output logic      [stx_pkg::DATA_W-1:0]    acc_q,
  output logic                               zero_flag_q,
  output logic      [7:0]                    table_high_register_q,
  output logic      [stx_pkg::PC_W-1:0]      prog_addr_q,
  output logic      [stx_pkg::DATA_W-1:0]    mem_rd_data_q
);

  // ****************************************************************
  // Operand fetch and decode
  // ****************************************************************
  stx_pkg::stx_state_t state_q;
  stx_pkg::stx_state_t state_d;

  logic                          op_pend_q;
  stx_pkg::stx_op_t              op_q;
  logic [2:0]                    bit_q;
  logic [stx_pkg::DATA_W-1:0]    imm_q;
  logic [stx_pkg::RAM_AW-1:0]    addr_q;
  logic [stx_pkg::DATA_W-1:0]    ram_rd;
  logic [stx_pkg::DATA_W-1:0]    ram_wdata;
  logic                          ram_we;

  // Operand is read one cycle after the op is accepted
  wire take       = op_valid && op_ready_q;
  wire exec_now   = op_pend_q && (state_q == stx_pkg::STX_ST_EXEC);
  wire is_sz      = (op_q == stx_pkg::STX_OP_SKIP_ZERO);
  wire is_sza     = (op_q == stx_pkg::STX_OP_MOVE_SKIP);
  wire is_szb     = (op_q == stx_pkg::STX_OP_SKIP_BIT);
  wire is_tcur    = (op_q == stx_pkg::STX_OP_TABLE_CUR);
  wire is_tlast   = (op_q == stx_pkg::STX_OP_TABLE_LAST);
  wire is_xacc    = (op_q == stx_pkg::STX_OP_XOR_ACC);
  wire is_xmem    = (op_q == stx_pkg::STX_OP_XOR_MEM);
  wire is_ximm    = (op_q == stx_pkg::STX_OP_XOR_IMM);
  wire is_table   = is_tcur || is_tlast;
  wire byte_zero  = (ram_rd == 8'h00);
  wire bit_zero   = ~ram_rd[bit_q];

  // ****************************************************************
  // Execution datapath
  // ****************************************************************
  // skip on zero byte, or on zero selected bit for STX_OP_SKIP_BIT
  wire skip_take  = exec_now && (((is_sz || is_sza) && byte_zero) || (is_szb && bit_zero));

  wire [7:0] xor_opnd = is_ximm ? imm_q : ram_rd;
  wire [7:0] xor_res  = acc_q ^ xor_opnd;
  wire       xor_op   = is_xacc || is_xmem || is_ximm;

  // current page keeps PC high bits
  wire [1:0] page_sel = is_tlast ? stx_pkg::LAST_PAGE : pc_q[9:8];
  wire [9:0] tbl_addr = {page_sel, table_pointer};

  // low byte to memory on table read
  assign ram_we    = (exec_now && is_xmem) || (op_pend_q && state_q == stx_pkg::STX_ST_TABLE);
  assign ram_wdata = is_xmem ? xor_res : prog_rd_data[7:0];

  stx_ram u_ram
  (
    .mclk      (mclk),
    .wr_en     (ram_we),
    .addr      (take ? mem_addr : addr_q),
    .wr_data   (ram_wdata),
    .rd_data_q (ram_rd)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      stx_pkg::STX_ST_EXEC:
      begin
        if (skip_take)
          state_d = stx_pkg::STX_ST_DUMMY;
        else if (exec_now && is_table)
          state_d = stx_pkg::STX_ST_TABLE;
      end
      stx_pkg::STX_ST_DUMMY: state_d = stx_pkg::STX_ST_EXEC;
      stx_pkg::STX_ST_TABLE: state_d = stx_pkg::STX_ST_EXEC;
      default:               state_d = stx_pkg::STX_ST_EXEC;
    endcase
  end

  wire finish = (exec_now && !skip_take && !is_table) ||
                (op_pend_q && state_q != stx_pkg::STX_ST_EXEC);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_q   <= stx_pkg::STX_ST_EXEC;
      op_pend_q <= 1'b0;
      op_q      <= stx_pkg::STX_OP_NONE;
      addr_q    <= '0;
      bit_q     <= 3'h0;
      imm_q     <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (take)
      begin
        op_pend_q <= 1'b1;
        op_q      <= op_sel;
        addr_q    <= mem_addr;
        bit_q     <= bit_sel;
        imm_q     <= imm_data;
      end
      else if (finish)
        op_pend_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Architectural state
  // ****************************************************************
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      op_ready_q            <= 1'b1;
      op_done_q             <= 1'b0;
      skip_q                <= 1'b0;
      pc_q                  <= stx_pkg::PC_RST;
      acc_q                 <= stx_pkg::ACC_RST;
      zero_flag_q           <= 1'b0;
      table_high_register_q <= {2'b00, stx_pkg::HIGH_RST};
      prog_addr_q           <= stx_pkg::PC_RST;
      mem_rd_data_q         <= 8'h00;
    end
    else
    begin
      op_ready_q    <= !take && !(op_pend_q && !finish);
      op_done_q     <= finish;
      skip_q        <= skip_take;
      mem_rd_data_q <= ram_rd;
      if (exec_now)
        prog_addr_q <= tbl_addr;
      // dummy cycle advances past skipped word
      if (op_pend_q && state_q == stx_pkg::STX_ST_DUMMY)
        pc_q <= pc_q + 10'h002;
      else if (finish)
        pc_q <= pc_q + 10'h001;
      if (exec_now && is_sza)
        acc_q <= ram_rd;
      else if (exec_now && (is_xacc || is_ximm))
        acc_q <= xor_res;
      if (exec_now && xor_op)
        zero_flag_q <= (xor_res == 8'h00);
      // upper two bits held at zero
      if (op_pend_q && state_q == stx_pkg::STX_ST_TABLE)
        table_high_register_q <= {2'b00, prog_rd_data[13:8]};
    end
  end

endmodule

/* File: testbench/stx_exec_chk.sv */
`timescale 1ns/1ps
module stx_exec_chk
(
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic             op_valid,
  input wire stx_pkg::stx_op_t op_sel,
  input wire logic [7:0]       imm_data,
  input wire logic             op_ready_q,
  input wire logic             op_done_q,
  input wire logic             skip_q,
  input wire logic [9:0]       pc_q,
  input wire logic [7:0]       acc_q,
  input wire logic             zero_flag_q,
  input wire logic [7:0]       table_high_register_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence take_s;
    op_valid && op_ready_q;
  endsequence
  sequence xor_s;
    take_s ##0 op_sel[7:5] != 3'b000;
  endsequence
  sequence imm_s;
    take_s ##0 op_sel == stx_pkg::STX_OP_XOR_IMM;
  endsequence
  ready_drop_a: assert property (take_s |=> !op_ready_q) // busy
    else $error("ready stayed high after take");
  plain_done_a: assert property (xor_s |-> ##2 op_done_q) // done two cycles after take
    else $error("xor did not finish in two cycles");
  imm_xor_a: assert property (imm_s |-> ##2 acc_q == ($past(acc_q, 2) ^ // result
    $past(imm_data, 2)) && zero_flag_q == (acc_q == 8'h00))
    else $error("immediate xor result wrong");
  skip_dummy_a: assert property (skip_q |=> op_done_q && op_ready_q) // dummy
    else $error("skip did not end after dummy cycle");
  skip_pc_a: assert property (skip_q |=> pc_q == $past(pc_q) + 10'h002) // skip pc
    else $error("pc did not pass skipped instruction");
  pc_move_a: assert property ($changed(pc_q) |-> op_done_q) // pc step
    else $error("pc moved outside completion");
  flag_move_a: assert property ($changed(zero_flag_q) |-> op_done_q) // flag
    else $error("zero flag moved outside completion");
  skip_flag_a: assert property (skip_q |=> $stable(zero_flag_q)) // no flag
    else $error("skip changed zero flag");
  high_zero_a: assert property (table_high_register_q[7:6] == 2'b00) // top
    else $error("table high unused bits set");
  high_move_a: assert property ($changed(table_high_register_q) |-> op_done_q) // table
    else $error("table high moved outside completion");
  cover property (skip_q);
endmodule
bind stx_exec stx_exec_chk chk (.*);

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic             mclk = 1'b0;
  logic             rst_n = 1'b0;
  logic             op_valid = 1'b0;
  stx_pkg::stx_op_t op_sel = stx_pkg::STX_OP_NONE;
  logic [4:0]       mem_addr = 5'h00;
  logic [2:0]       bit_sel = 3'h0;
  logic [7:0]       imm_data = 8'h00;
  logic [7:0]       table_pointer = 8'h00;
  logic [13:0]      prog_rd_data;
  logic             op_ready_q, op_done_q, skip_q, zero_flag_q, z = 1'b0;
  logic [9:0]       pc_q, prog_addr_q, pc = 10'h000;
  logic [7:0]       acc_q, table_high_register_q, mem_rd_data_q, acc = 8'h00;
  logic [7:0]       mem [32];
  logic [31:0]      rs = 32'h0000_0009, r;
  int               miscompares = 0;
  int               samples_checked = 0;
  stx_exec dut (.*);
  // ****
  // Program memory and helpers
  // ****
  function automatic logic [13:0] rom(input logic [9:0] a);
    return {a[9:4], a[7:0] ^ 8'h5a};
  endfunction
  assign prog_rd_data = rom(prog_addr_q);
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_sim();
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic go(input int k, input logic [4:0] a, input logic [2:0] b,
                    input logic [7:0] i, input logic [7:0] t);
    int          n;
    logic        sk;
    logic        sw;
    logic [7:0]  m;
    logic [13:0] w;
    n = 0;
    sk = 1'b0;
    sw = 1'b0;
    m = mem[a];
    w = rom({(k == 3) ? pc[9:8] : 2'h3, t});
    op_sel <= stx_pkg::stx_op_t'(8'h01 << k);
    mem_addr <= a;
    bit_sel <= b;
    imm_data <= i;
    table_pointer <= t;
    op_valid <= 1'b1;
    @(posedge mclk);
    op_valid <= 1'b0;
    while (op_done_q !== 1'b1 && n < 6)
    begin
      @(negedge mclk);
      n++;
      sw |= (skip_q === 1'b1);
      // Memory byte as read for this op, known once written
      if (n == 2 && !$isunknown(m))
        chk(mem_rd_data_q, m); // memory byte
    end
    case (k)
      0: sk = (m == 8'h00);
      1:
      begin
        sk = (m == 8'h00);
        acc = m;
      end
      2: sk = !m[b];
      3, 4:
      begin
        mem[a] = w[7:0];
        chk(table_high_register_q, {2'b00, w[13:8]}); // high
      end
      5: acc ^= m;
      6: mem[a] = acc ^ m;
      7: acc ^= i;
      default: ;
    endcase
    if (k > 4) z = (((k == 6) ? mem[a] : acc) == 8'h00);
    pc += sk ? 10'h002 : 10'h001;
    chk(n, (sk || k == 3 || k == 4) ? 3 : 2); // cycle count
    chk(sw, sk); // skip taken
    chk(acc_q, acc); // accumulator
    chk(zero_flag_q, z); // zero flag
    chk(pc_q, pc); // pc advance
    @(posedge mclk);
  endtask
  initial forever #12.5 mclk = ~mclk;
  initial
  begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    end_sim();
  end
  // ****
  // Table fill, corners, random mix
  // ****
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 32; a++)
      go(3, 5'(a), 3'h0, 8'h00, (a < 4) ? 8'h5a : 8'(xs()));
    for (int k = 0; k < 8; k++)
      go(k, 5'h01, 3'(k), acc, 8'h5a);
    repeat (300)
    begin
      r = xs();
      go(int'(r[2:0]), r[7:3], r[10:8], r[18:11], r[26:19]);
    end
    end_sim();
  end
endmodule
